// ### core/ctt_io.sv
// Chuck, tailstock and electric tool post output sequencer with APB registers
//
// Design decisions made here: the APB interface to the registers and the register offsets.

// Millisecond pulse stretcher for chuck and tailstock pulse outputs
module ctt_pulse_timer (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ms_tick,
   input wire logic start,
   input wire logic [15:0] dur,
   output logic active
);
   logic [15:0] left;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         left <= 16'h0000;
         active <= 1'b0;
      end else if (start) begin
         left <= dur;
         active <= (dur != 16'h0000);
      end else if (ms_tick && active) begin
         left <= left - 16'h0001;
         active <= (left != 16'h0001);
      end
   end
endmodule : ctt_pulse_timer

module ctt_io
   import ctt_pkg::*;
#(
   parameter int TICK_CYCLES = CYC_PER_MS,
   parameter int TOOL_POSITIONS = 12
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic irq,
   input wire logic [3:0] tool_code,
   input wire logic tool_code_strobe,
   input wire logic clamp_in_position,
   input wire logic chuck_clamped_ack,
   input wire logic chuck_released_ack,
   input wire logic chuck_foot_switch,
   input wire logic tail_foot_switch,
   output logic tool_cw,
   output logic tool_ccw,
   output logic chuck_clamp,
   output logic chuck_release,
   output logic tail_advance,
   output logic tail_retract
);
   logic [7:0] chuck_tailstock_config;
   logic [15:0] ccw_clamp_time, rotation_time_limit, cw_to_ccw_delay;
   logic [15:0] chuck_pulse_time, tailstock_pulse_time;
   logic tcp_used;
   logic [IRQ_W-1:0] irq_status, irq_mask, irq_set;
   logic [4:0] cmd;
   logic [3:0] target;
   logic wr_en;
   logic [9:0] pins, sync1, sync2, sync3, pin_q, pin_d, agree;
   logic [3:0] code_q;
   logic strobe_q, tcp_q, ack_c_q, ack_r_q, foot_c_q, foot_t_q;
   logic [15:0] tick_cnt;
   logic ms_tick;
   ctt_tp_state_t tp_state;
   logic [15:0] tp_ms;
   logic tool_done, tool_alarm, tool_rej;
   logic chuck_clamped, chuck_known, chuck_dir, chuck_go, chuck_rej;
   logic clamp_req, release_req, chuck_pulse_on, ack_ok, ack_ok_d;
   logic tail_adv_state, tail_known, tail_dir, tail_go, tail_rej;
   logic adv_req, ret_req, tail_pulse_on;

   // Pin inputs: three stages, accept a level once stages two and three agree
   assign pins = {tool_code, tool_code_strobe, clamp_in_position,
                  chuck_clamped_ack, chuck_released_ack,
                  chuck_foot_switch, tail_foot_switch};
   assign agree = ~(sync2 ^ sync3);
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync1 <= 10'h000;
         sync2 <= 10'h000;
         sync3 <= 10'h000;
         pin_q <= 10'h000;
         pin_d <= 10'h000;
      end else begin
         sync1 <= pins;
         sync2 <= sync1;
         sync3 <= sync2;
         pin_q <= (pin_q & ~agree) | (sync3 & agree);
         pin_d <= pin_q;
      end
   end
   assign {code_q, strobe_q, tcp_q, ack_c_q, ack_r_q, foot_c_q, foot_t_q}
      = pin_q;

   // Millisecond enable
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tick_cnt <= 16'h0000;
         ms_tick <= 1'b0;
      end else begin
         ms_tick <= (tick_cnt == 16'(TICK_CYCLES - 1));
         tick_cnt <= (tick_cnt == 16'(TICK_CYCLES - 1)) ? 16'h0000
                     : tick_cnt + 16'h0001;
      end
   end

   // APB: no wait state; pready is a flop like every other output
   assign wr_en = psel && penable && pready && pwrite;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end else begin
         pready <= psel && !penable && !pready;
         if (psel && !penable) begin
            pslverr <= paddr > OFF_IRQ_MASK || paddr[1:0] != 2'b00;
            unique case (paddr)
               OFF_CONFIG: prdata <= {24'h000000, chuck_tailstock_config};
               OFF_CCW_TIME: prdata <= {16'h0000, ccw_clamp_time};
               OFF_ROT_LIMIT: prdata <= {16'h0000, rotation_time_limit};
               OFF_CW_CCW_DLY: prdata <= {16'h0000, cw_to_ccw_delay};
               OFF_CHUCK_PULSE: prdata <= {16'h0000, chuck_pulse_time};
               OFF_TAIL_PULSE: prdata <= {16'h0000, tailstock_pulse_time};
               OFF_TOOL_CTRL: prdata <= {31'h00000000, tcp_used};
               OFF_STATUS: prdata <= {22'h000000, tail_adv_state, ack_ok,
                  chuck_clamped, strobe_q, code_q, tp_state};
               OFF_IRQ_STATUS: prdata <= {27'h0000000, irq_status};
               OFF_IRQ_MASK: prdata <= {27'h0000000, irq_mask};
               default: prdata <= 32'h0000_0000;
            endcase
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         chuck_tailstock_config <= CONFIG_RST;
         ccw_clamp_time <= CCW_TIME_RST;
         rotation_time_limit <= ROT_LIMIT_RST;
         cw_to_ccw_delay <= CW_CCW_DLY_RST;
         chuck_pulse_time <= CHUCK_PULSE_RST;
         tailstock_pulse_time <= TAIL_PULSE_RST;
         tcp_used <= 1'b0;
         irq_mask <= '0;
      end else if (wr_en) begin
         unique case (paddr)
            OFF_CONFIG: chuck_tailstock_config <= pwdata[7:0];
            OFF_CCW_TIME: ccw_clamp_time <= pwdata[15:0];
            OFF_ROT_LIMIT: rotation_time_limit <= pwdata[15:0];
            OFF_CW_CCW_DLY: cw_to_ccw_delay <= pwdata[15:0];
            OFF_CHUCK_PULSE: chuck_pulse_time <= pwdata[15:0];
            OFF_TAIL_PULSE: tailstock_pulse_time <= pwdata[15:0];
            OFF_TOOL_CTRL: tcp_used <= pwdata[CTRL_TCP_USED];
            OFF_IRQ_MASK: irq_mask <= pwdata[IRQ_W-1:0];
            default: ;
         endcase
      end
   end

   // Command writes become one-cycle strobes
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cmd <= 5'h00;
         target <= 4'h0;
      end else begin
         cmd <= (wr_en && paddr == OFF_COMMAND) ? pwdata[4:0] : 5'h00;
         if (wr_en && paddr == OFF_COMMAND && pwdata[CMD_TOOL])
            target <= pwdata[CMD_TARGET_LSB +: 4];
      end
   end

   // Sticky events: a set in the clearing cycle survives
   assign irq_set = {ack_ok && !ack_ok_d
                        && chuck_tailstock_config[CFG_CHUCK_ACK],
                     tail_rej, chuck_rej, tool_alarm | tool_rej, tool_done};
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_status <= '0;
         irq <= 1'b0;
      end else begin
         irq_status <= (irq_status
            & ~((wr_en && paddr == OFF_IRQ_STATUS) ? pwdata[IRQ_W-1:0] : '0))
            | irq_set;
         irq <= |(irq_status & irq_mask);
      end
   end

   // Tool post: clockwise search, delay, counter-clockwise clamp
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tp_state <= TP_IDLE;
         tp_ms <= 16'h0000;
         tool_cw <= 1'b0;
         tool_ccw <= 1'b0;
         tool_done <= 1'b0;
         tool_alarm <= 1'b0;
         tool_rej <= 1'b0;
      end else begin
         tool_done <= 1'b0;
         tool_alarm <= 1'b0;
         tool_rej <= 1'b0;
         if (ms_tick)
            tp_ms <= tp_ms + 16'h0001;
         unique case (tp_state)
            TP_IDLE: begin
               if (cmd[CMD_TOOL]) begin
                  if (target == 4'h0 || 32'(target) > TOOL_POSITIONS) begin
                     tool_rej <= 1'b1;
                  end else begin
                     tp_state <= TP_CW;
                     tp_ms <= 16'h0000;
                     tool_cw <= 1'b1;
                  end
               end
            end
            TP_CW: begin
               if (strobe_q && code_q == target) begin
                  tp_state <= TP_DELAY;
                  tp_ms <= 16'h0000;
                  tool_cw <= 1'b0;
               end else if (tp_ms >= rotation_time_limit) begin
                  tp_state <= TP_IDLE;
                  tool_cw <= 1'b0;
                  tool_alarm <= 1'b1;
               end
            end
            TP_DELAY: begin
               if (tp_ms >= cw_to_ccw_delay) begin
                  tp_state <= TP_CCW;
                  tp_ms <= 16'h0000;
                  tool_ccw <= 1'b1;
               end
            end
            TP_CCW: begin
               if (tcp_used && tcp_q) begin
                  tp_state <= TP_IDLE;
                  tool_ccw <= 1'b0;
                  tool_done <= 1'b1;
               end else if (tp_ms >= ccw_clamp_time) begin
                  tp_state <= TP_IDLE;
                  tool_ccw <= 1'b0;
                  tool_done <= !tcp_used;
                  tool_alarm <= tcp_used;
               end
            end
         endcase
      end
   end

   // Chuck: program commands plus foot switch toggling
   assign clamp_req = cmd[CMD_CLAMP] || (foot_c_q && !pin_d[1]
      && !chuck_tailstock_config[CFG_CHUCK_FOOT_OFF] && !chuck_clamped);
   assign release_req = cmd[CMD_RELEASE] || (foot_c_q && !pin_d[1]
      && !chuck_tailstock_config[CFG_CHUCK_FOOT_OFF] && chuck_clamped);
   assign ack_ok = chuck_known && (chuck_clamped ? ack_c_q : ack_r_q);
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         chuck_clamped <= 1'b0;
         chuck_known <= 1'b0;
         chuck_dir <= 1'b0;
         chuck_go <= 1'b0;
         chuck_rej <= 1'b0;
         ack_ok_d <= 1'b0;
      end else begin
         ack_ok_d <= ack_ok;
         chuck_go <= 1'b0;
         chuck_rej <= 1'b0;
         if (clamp_req || release_req) begin
            if (chuck_tailstock_config[CFG_CHUCK_OFF]) begin
               chuck_rej <= 1'b1;
            end else begin
               chuck_clamped <= clamp_req;
               chuck_known <= 1'b1;
               // Inner gripping closes by driving the release side
               chuck_dir <= clamp_req
                  ^ chuck_tailstock_config[CFG_INNER];
               chuck_go <= 1'b1;
            end
         end
      end
   end

   ctt_pulse_timer chuck_timer (
      .pclk(pclk),
      .presetn(presetn),
      .ms_tick(ms_tick),
      .start(chuck_go),
      .dur(chuck_pulse_time),
      .active(chuck_pulse_on)
   );

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         chuck_clamp <= 1'b0;
         chuck_release <= 1'b0;
      end else if (chuck_tailstock_config[CFG_CHUCK_PULSE]) begin
         chuck_clamp <= chuck_pulse_on && chuck_dir;
         chuck_release <= chuck_pulse_on && !chuck_dir;
      end else begin
         chuck_clamp <= chuck_known && chuck_dir;
         chuck_release <= chuck_known && !chuck_dir;
      end
   end

   // Tailstock: same scheme as the chuck, no gripping sense
   assign adv_req = cmd[CMD_ADVANCE] || (foot_t_q && !pin_d[0]
      && !chuck_tailstock_config[CFG_TAIL_FOOT_OFF] && !tail_adv_state);
   assign ret_req = cmd[CMD_RETRACT] || (foot_t_q && !pin_d[0]
      && !chuck_tailstock_config[CFG_TAIL_FOOT_OFF] && tail_adv_state);
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tail_adv_state <= 1'b0;
         tail_known <= 1'b0;
         tail_dir <= 1'b0;
         tail_go <= 1'b0;
         tail_rej <= 1'b0;
      end else begin
         tail_go <= 1'b0;
         tail_rej <= 1'b0;
         if (adv_req || ret_req) begin
            if (chuck_tailstock_config[CFG_TAIL_OFF]) begin
               tail_rej <= 1'b1;
            end else begin
               tail_adv_state <= adv_req;
               tail_known <= 1'b1;
               tail_dir <= adv_req;
               tail_go <= 1'b1;
            end
         end
      end
   end

   ctt_pulse_timer tail_timer (
      .pclk(pclk),
      .presetn(presetn),
      .ms_tick(ms_tick),
      .start(tail_go),
      .dur(tailstock_pulse_time),
      .active(tail_pulse_on)
   );

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tail_advance <= 1'b0;
         tail_retract <= 1'b0;
      end else if (chuck_tailstock_config[CFG_TAIL_PULSE]) begin
         tail_advance <= tail_pulse_on && tail_dir;
         tail_retract <= tail_pulse_on && !tail_dir;
      end else begin
         tail_advance <= tail_known && tail_dir;
         tail_retract <= tail_known && !tail_dir;
      end
   end
endmodule : ctt_io

// ### core/ctt_pkg.sv
// Register map, field layout and timing constants of the chuck/tool post block
package ctt_pkg;
   localparam logic [7:0] OFF_CONFIG = 8'h00;
   localparam logic [7:0] OFF_CCW_TIME = 8'h04;
   localparam logic [7:0] OFF_ROT_LIMIT = 8'h08;
   localparam logic [7:0] OFF_CW_CCW_DLY = 8'h0c;
   localparam logic [7:0] OFF_CHUCK_PULSE = 8'h10;
   localparam logic [7:0] OFF_TAIL_PULSE = 8'h14;
   localparam logic [7:0] OFF_TOOL_CTRL = 8'h18;
   localparam logic [7:0] OFF_COMMAND = 8'h1c;
   localparam logic [7:0] OFF_STATUS = 8'h20;
   localparam logic [7:0] OFF_IRQ_STATUS = 8'h24;
   localparam logic [7:0] OFF_IRQ_MASK = 8'h28;

   localparam int CFG_CHUCK_OFF = 7;
   localparam int CFG_INNER = 6;
   localparam int CFG_CHUCK_ACK = 5;
   localparam int CFG_TAIL_OFF = 4;
   localparam int CFG_CHUCK_PULSE = 3;
   localparam int CFG_TAIL_PULSE = 2;
   localparam int CFG_CHUCK_FOOT_OFF = 1;
   localparam int CFG_TAIL_FOOT_OFF = 0;

   localparam int CMD_CLAMP = 0;
   localparam int CMD_RELEASE = 1;
   localparam int CMD_ADVANCE = 2;
   localparam int CMD_RETRACT = 3;
   localparam int CMD_TOOL = 4;
   localparam int CMD_TARGET_LSB = 8;
   localparam int CTRL_TCP_USED = 0;

   localparam int IRQ_TOOL_DONE = 0;
   localparam int IRQ_TOOL_ALARM = 1;
   localparam int IRQ_CHUCK_REJ = 2;
   localparam int IRQ_TAIL_REJ = 3;
   localparam int IRQ_CHUCK_ACK = 4;
   localparam int IRQ_W = 5;

   localparam logic [7:0] CONFIG_RST = 8'h00;
   localparam logic [15:0] CCW_TIME_RST = 16'h01f4;
   localparam logic [15:0] ROT_LIMIT_RST = 16'h1388;
   localparam logic [15:0] CW_CCW_DLY_RST = 16'h0032;
   localparam logic [15:0] CHUCK_PULSE_RST = 16'h01f4;
   localparam logic [15:0] TAIL_PULSE_RST = 16'h01f4;

   localparam int CLK_NS = 50;
   localparam int MS_NS = 1000000;
   localparam int CYC_PER_MS = MS_NS / CLK_NS;

   typedef enum logic [1:0] {
      TP_IDLE = 2'b00,
      TP_CW = 2'b01,
      TP_DELAY = 2'b10,
      TP_CCW = 2'b11
   } ctt_tp_state_t;
endpackage : ctt_pkg

// ### verif/ctt_io_properties.sv
// Port checker of the chuck, tailstock and tool post sequencer
module ctt_io_properties
   import ctt_pkg::*;
#(
   parameter int TICK_CYCLES = CYC_PER_MS,
   parameter int TOOL_POSITIONS = 12
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic tool_cw,
   input wire logic tool_ccw,
   input wire logic chuck_clamp,
   input wire logic chuck_release,
   input wire logic tail_advance,
   input wire logic tail_retract
);
   timeunit 1ns;
   timeprecision 1ns;
   logic wr;
   logic cmd;
   logic tool_go;
   logic bad_tgt;
   logic [7:0] cfg;
   logic [15:0] ccw_t;
   int ccw_cnt;
   assign wr = psel && penable && pready && pwrite;
   assign cmd = wr && paddr == OFF_COMMAND;
   assign tool_go = cmd && pwdata[CMD_TOOL] && !tool_cw && !tool_ccw;
   assign bad_tgt = pwdata[11:8] == 4'h0
      || int'(pwdata[11:8]) > TOOL_POSITIONS;
   // Shadow copies of the settings the properties depend on
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cfg <= CONFIG_RST;
         ccw_t <= CCW_TIME_RST;
      end else if (wr && paddr == OFF_CONFIG) begin
         cfg <= pwdata[7:0];
      end else if (wr && paddr == OFF_CCW_TIME) begin
         ccw_t <= pwdata[15:0];
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ccw_cnt <= 0;
      end else begin
         ccw_cnt <= tool_ccw ? ccw_cnt + 1 : 0;
      end
   end
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   chk_apb_ready: assert property (psel && !penable |=> pready ##1 !pready)
      else $error("pready is not a single access-cycle pulse");
   chk_err_unmapped: assert property (
      psel && !penable && paddr > OFF_IRQ_MASK |=> pslverr)
      else $error("unmapped address not flagged");
   chk_drive_excl: assert property (!(tool_cw && tool_ccw))
      else $error("cw and ccw driven together");
   chk_ccw_delay: assert property ($fell(tool_cw) |-> !tool_ccw [*8])
      else $error("ccw started without the delay");
   chk_ccw_capped: assert property (
      tool_ccw |-> ccw_cnt < int'(ccw_t) * TICK_CYCLES + 2)
      else $error("ccw held past the clamp time");
   chk_tool_start: assert property (
      tool_go && !bad_tgt |-> ##2 tool_cw)
      else $error("cw did not start two cycles after command");
   chk_bad_target: assert property (
      tool_go && bad_tgt |=> !tool_cw [*6])
      else $error("cw started for an impossible target");
   chk_chuck_off: assert property (
      cmd && cfg[CFG_CHUCK_OFF]
      |=> ($stable(chuck_clamp) && $stable(chuck_release)) [*5])
      else $error("disabled chuck outputs moved");
   chk_tail_off: assert property (
      cmd && cfg[CFG_TAIL_OFF]
      |=> ($stable(tail_advance) && $stable(tail_retract)) [*5])
      else $error("disabled tailstock outputs moved");
   chk_clamp_drive: assert property (
      cmd && pwdata[CMD_CLAMP] && !cfg[CFG_CHUCK_OFF]
      |-> ##3 (cfg[CFG_CHUCK_PULSE]
         || (cfg[CFG_INNER] ? chuck_release : chuck_clamp))
      ##1 (cfg[CFG_INNER] ? chuck_release : chuck_clamp))
      else $error("clamp command drove the wrong output");
   chk_level_excl: assert property (
      !cfg[CFG_CHUCK_PULSE] |-> !(chuck_clamp && chuck_release))
      else $error("both chuck levels high");
endmodule : ctt_io_properties

bind ctt_io ctt_io_properties #(
   .TICK_CYCLES(TICK_CYCLES),
   .TOOL_POSITIONS(TOOL_POSITIONS)
) chk_u (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
   .pslverr(pslverr), .tool_cw(tool_cw), .tool_ccw(tool_ccw),
   .chuck_clamp(chuck_clamp), .chuck_release(chuck_release),
   .tail_advance(tail_advance), .tail_retract(tail_retract)
);

// ### verif/ctt_machine.sv
// Behavioural tool post encoder, clamp sensor and chuck sensors
module ctt_machine #(
   parameter int STEP = 20
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic tcp_en,
   input wire logic tool_cw,
   input wire logic tool_ccw,
   input wire logic chuck_clamp,
   input wire logic chuck_release,
   output logic [3:0] tool_code,
   output logic tool_code_strobe,
   output logic clamp_in_position,
   output logic chuck_clamped_ack,
   output logic chuck_released_ack
);
   timeunit 1ns;
   timeprecision 1ns;
   int pos;
   int ph;
   int ccw_n;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pos <= 1;
         ph <= 0;
         ccw_n <= 0;
         chuck_clamped_ack <= 1'b0;
      end else begin
         if (tool_cw) begin
            ph <= (ph == STEP - 1) ? 0 : ph + 1;
            if (ph == STEP - 1) pos <= (pos == 12) ? 1 : pos + 1;
         end
         ccw_n <= tool_ccw ? ccw_n + 1 : 0;
         if (chuck_clamp) chuck_clamped_ack <= 1'b1;
         else if (chuck_release) chuck_clamped_ack <= 1'b0;
      end
   end
   // Code lines are garbage while the disc moves between stations
   assign tool_code_strobe = !(tool_cw && ph < 4);
   assign tool_code = tool_code_strobe ? 4'(pos) : ~4'(pos);
   assign clamp_in_position = tcp_en && ccw_n >= 5;
   assign chuck_released_ack = !chuck_clamped_ack;
endmodule : ctt_machine

// ### verif/tb_top.sv
// Self-checking bench of the chuck, tailstock and tool post sequencer
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   import ctt_pkg::*;
   localparam int TK = 10;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic tcp_en = 1'b0;
   logic chuck_foot_switch = 1'b0;
   logic tail_foot_switch = 1'b0;
   logic [31:0] prdata, rd;
   logic pready, pslverr, irq, se, tool_code_strobe, clamp_in_position;
   logic chuck_clamped_ack, chuck_released_ack, tool_cw, tool_ccw;
   logic chuck_clamp, chuck_release, tail_advance, tail_retract;
   logic [3:0] tool_code;
   logic [5:0] outs, snap;
   int num_errors = 0;
   int cmp_count = 0;
   int n;
   logic [7:0] ra[7] = '{OFF_CONFIG, OFF_CCW_TIME, OFF_ROT_LIMIT,
      OFF_CW_CCW_DLY, OFF_CHUCK_PULSE, OFF_TAIL_PULSE, OFF_IRQ_MASK};
   logic [31:0] rv[7] = '{32'h0, 32'h1f4, 32'h1388, 32'h32, 32'h1f4,
      32'h1f4, 32'h0};
   always #25 pclk = ~pclk;
   assign outs = {tail_retract, tail_advance, chuck_release, chuck_clamp,
      tool_ccw, tool_cw};
   ctt_io #(.TICK_CYCLES(TK), .TOOL_POSITIONS(12)) dut_u (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .irq(irq), .tool_code(tool_code),
      .tool_code_strobe(tool_code_strobe),
      .clamp_in_position(clamp_in_position),
      .chuck_clamped_ack(chuck_clamped_ack),
      .chuck_released_ack(chuck_released_ack),
      .chuck_foot_switch(chuck_foot_switch),
      .tail_foot_switch(tail_foot_switch), .tool_cw(tool_cw),
      .tool_ccw(tool_ccw), .chuck_clamp(chuck_clamp),
      .chuck_release(chuck_release), .tail_advance(tail_advance),
      .tail_retract(tail_retract));
   ctt_machine #(.STEP(20)) mach_u (
      .pclk(pclk), .presetn(presetn), .tcp_en(tcp_en), .tool_cw(tool_cw),
      .tool_ccw(tool_ccw), .chuck_clamp(chuck_clamp),
      .chuck_release(chuck_release), .tool_code(tool_code),
      .tool_code_strobe(tool_code_strobe),
      .clamp_in_position(clamp_in_position),
      .chuck_clamped_ack(chuck_clamped_ack),
      .chuck_released_ack(chuck_released_ack));
   task automatic summarize;
      $display("Comparisons %0d, errors %0d", cmp_count, num_errors);
      if (num_errors == 0 && cmp_count > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : summarize
   task automatic stall(input logic hit);
      if (hit) begin
         num_errors++;
         $display("[ERR] wait bound used up");
         summarize();
      end
   endtask : stall
   task automatic check(input string nm, input logic [31:0] e,
         input logic [31:0] g);
      cmp_count++;
      if (g !== e) begin
         num_errors++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask : check
   task automatic check_rng(input string nm, input int lo, input int hi);
      cmp_count++;
      if (n < lo || n > hi) begin
         num_errors++;
         $display("[ERR] %s expected %0d..%0d seen %0d", nm, lo, hi, n);
      end
   endtask : check_rng
   // Setup, then access held until pready is sampled high
   task automatic apb(input logic w, input logic [7:0] a,
         input logic [31:0] d);
      int k;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge pclk);
         k++;
      end while (pready !== 1'b1 && k < 20);
      rd = prdata;
      se = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      stall(k >= 20);
   endtask : apb
   task automatic rchk(input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      check($sformatf("word %h", a), e, rd);
   endtask : rchk
   task automatic cmd(input int b);
      apb(1'b1, OFF_COMMAND, 32'h1 << b);
   endtask : cmd
   task automatic tool(input int t);
      apb(1'b1, OFF_COMMAND, (32'(t) << CMD_TARGET_LSB) | 32'h10);
   endtask : tool
   task automatic wt(input int c);
      repeat (c) @(posedge pclk);
   endtask : wt
   // Cycles that output i stays high, after it first rises
   task automatic len(input int i);
      int k;
      k = 0;
      while (outs[i] !== 1'b1 && k < 3000) begin
         @(posedge pclk);
         k++;
      end
      n = 0;
      while (outs[i] === 1'b1 && n < 3000) begin
         @(posedge pclk);
         n++;
      end
      stall(k >= 3000 || n >= 3000);
   endtask : len
   task automatic press(input logic c);
      if (c) chuck_foot_switch <= 1'b1;
      else tail_foot_switch <= 1'b1;
      wt(10);
      chuck_foot_switch <= 1'b0;
      tail_foot_switch <= 1'b0;
      wt(20);
   endtask : press
   initial begin
      wt(4);
      presetn <= 1'b1;
      foreach (ra[i]) rchk(ra[i], rv[i]);
      rchk(8'h2c, 32'h0);
      check("pslverr", 1'b1, se);
      apb(1'b1, OFF_CCW_TIME, 32'd3);
      apb(1'b1, OFF_ROT_LIMIT, 32'd20);
      apb(1'b1, OFF_CW_CCW_DLY, 32'd2);
      apb(1'b1, OFF_CHUCK_PULSE, 32'd4);
      apb(1'b1, OFF_TAIL_PULSE, 32'd5);
      apb(1'b1, OFF_IRQ_MASK, 32'h1f);
      rchk(OFF_CCW_TIME, 32'd3);
      tool(5);
      len(1);
      check_rng("ccw time", 2 * TK, 3 * TK + 2);
      wt(5);
      check("irq", 1'b1, irq);
      rchk(OFF_IRQ_STATUS, 32'h1);
      rchk(OFF_STATUS, 32'h54);
      apb(1'b1, OFF_IRQ_STATUS, 32'h1f);
      rchk(OFF_IRQ_STATUS, 32'h0);
      check("irq", 1'b0, irq);
      apb(1'b1, OFF_TOOL_CTRL, 32'h1);
      tcp_en <= 1'b1;
      tool(8);
      len(1);
      check_rng("ccw sensed", 5, 16);
      wt(5);
      rchk(OFF_IRQ_STATUS, 32'h1);
      apb(1'b1, OFF_IRQ_STATUS, 32'h1f);
      tcp_en <= 1'b0;
      tool(10);
      len(1);
      check_rng("ccw cap", 2 * TK, 3 * TK + 2);
      wt(5);
      rchk(OFF_IRQ_STATUS, 32'h2);
      apb(1'b1, OFF_IRQ_STATUS, 32'h1f);
      apb(1'b1, OFF_ROT_LIMIT, 32'd2);
      tool(9);
      len(0);
      check_rng("cw limit", TK, 2 * TK + 4);
      wt(40);
      check("ccw idle", 1'b0, tool_ccw);
      rchk(OFF_IRQ_STATUS, 32'h2);
      apb(1'b1, OFF_IRQ_STATUS, 32'h1f);
      apb(1'b1, OFF_ROT_LIMIT, 32'd20);
      apb(1'b1, OFF_IRQ_MASK, 32'h0);
      for (int t = 0; t < 2; t++) begin
         tool(t * 13);
         wt(8);
         check("cw idle", 1'b0, tool_cw);
         rchk(OFF_IRQ_STATUS, 32'h2);
         check("irq masked", 1'b0, irq);
      end
      apb(1'b1, OFF_IRQ_MASK, 32'h1f);
      wt(2);
      check("irq", 1'b1, irq);
      apb(1'b1, OFF_IRQ_STATUS, 32'h1f);
      wt(2);
      check("irq", 1'b0, irq);
      for (int g = 0; g < 2; g++) begin
         apb(1'b1, OFF_CONFIG, 32'(g) << CFG_INNER);
         cmd(CMD_CLAMP);
         wt(50);
         check("clamp", g ? 32'h2 : 32'h1, 32'(outs[3:2]));
         cmd(CMD_RELEASE);
         wt(50);
         check("release", g ? 32'h1 : 32'h2, 32'(outs[3:2]));
      end
      apb(1'b1, OFF_CONFIG, 32'h08);
      cmd(CMD_CLAMP);
      len(2);
      check_rng("chuck pulse", 3 * TK, 4 * TK + 2);
      apb(1'b1, OFF_CONFIG, 32'h04);
      cmd(CMD_ADVANCE);
      len(4);
      check_rng("tail pulse", 4 * TK, 5 * TK + 2);
      apb(1'b1, OFF_CONFIG, 32'h0);
      cmd(CMD_RETRACT);
      wt(70);
      check("tail level", 1'b1, tail_retract);
      apb(1'b1, OFF_CONFIG, 32'h90);
      wt(5);
      snap = outs;
      apb(1'b1, OFF_COMMAND, 32'h5);
      wt(10);
      check("outputs", snap, outs);
      rchk(OFF_IRQ_STATUS, 32'hc);
      apb(1'b1, OFF_CONFIG, 32'h20);
      cmd(CMD_RELEASE);
      wt(20);
      apb(1'b1, OFF_IRQ_STATUS, 32'h1f);
      cmd(CMD_CLAMP);
      wt(20);
      rchk(OFF_IRQ_STATUS, 32'h10);
      apb(1'b1, OFF_CONFIG, 32'h0);
      cmd(CMD_RELEASE);
      press(1'b1);
      check("foot clamp", 1'b1, chuck_clamp);
      apb(1'b1, OFF_CONFIG, 32'h02);
      press(1'b1);
      check("foot off", 1'b1, chuck_clamp);
      apb(1'b1, OFF_CONFIG, 32'h0);
      cmd(CMD_RETRACT);
      press(1'b0);
      check("foot advance", 1'b1, tail_advance);
      apb(1'b1, OFF_CONFIG, 32'h01);
      press(1'b0);
      check("foot off", 1'b1, tail_advance);
      summarize();
   end
endmodule : tb_top
